// File: inc/pmiv_defs.svh
`ifndef PMIV_DEFS_SVH
`define PMIV_DEFS_SVH

// Register byte offsets on the APB bus.
`define PMIV_A_MODE 8'h00
`define PMIV_A_CTRL 8'h04
`define PMIV_A_STAT 8'h08
`define PMIV_A_VEC 8'h0C
`define PMIV_A_EVT 8'h10
`define PMIV_A_MASK 8'h14

// Operating mode codes held in the mode register.
`define PMIV_M_RUN 3'h0
`define PMIV_M_S0 3'h1
`define PMIV_M_S1 3'h2
`define PMIV_M_S2 3'h3
`define PMIV_M_S3 3'h4
`define PMIV_M_S4 3'h5

// Gate enables, packed as {cpu, main, sub, aux, bias, xtal}.
`define PMIV_G_RUN 6'h3F
`define PMIV_G_S0 6'h0F
`define PMIV_G_S2 6'h07
`define PMIV_G_S3 6'h05
`define PMIV_G_S4 6'h00

// Control register bit positions.
`define PMIV_C_GIE 0
`define PMIV_C_NMIEN 1
`define PMIV_C_OFEN 2
`define PMIV_C_ACCEN 3
`define PMIV_C_WATCHDOG_IRQ_ENABLE 4
`define PMIV_C_WDTIVL 5
`define PMIV_C_DCORUN 6
`define PMIV_CTRL_W 7
`define PMIV_CTRL_RST 7'h00

// Event register bit positions.
`define PMIV_E_WAKE 0
`define PMIV_E_FETCH 1
`define PMIV_E_BLANK 2
`define PMIV_E_RESET 3
`define PMIV_EVT_W 4

// Vector table and priorities.
`define PMIV_VEC_BASE 16'hFFC0
`define PMIV_VEC_RST 16'hFFFE
`define PMIV_BLANK_WORD 16'hFFFF
`define PMIV_P_RST 5'h1F
`define PMIV_P_NMI 5'h1E
`define PMIV_P_WDT 5'h1A
`define PMIV_P_CC0 5'h19
`define PMIV_P_CC12 5'h18
`define PMIV_P_CONV 5'h15
`define PMIV_P_SER 5'h14
`define PMIV_P_PORT2 5'h13
`define PMIV_P_PORT1 5'h12

// Fetchable address ranges; everything else is refused.
`define PMIV_RAM_LO 16'h0200
`define PMIV_RAM_HI 16'h02FF
`define PMIV_INFO_LO 16'h1000
`define PMIV_INFO_HI 16'h10FF
`define PMIV_CODE_LO 16'hF000

`endif

// File: inc/pmiv_pkg.sv
`default_nettype none
package pmiv_pkg;
    typedef enum logic [3:0] {
        PMIV_BOOT = 4'h1,
        PMIV_RUN = 4'h2,
        PMIV_SLEEP = 4'h4,
        PMIV_SVC = 4'h8
    } pmiv_state_t;
    typedef logic [2:0] pmiv_mode_t;
endpackage
`default_nettype wire

// File: core/pmiv_prio.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmiv_defs.svh"
module pmiv_prio
    import pmiv_pkg::*;
(
    input wire logic [31:0] pend, // Pending lines indexed by priority.
    output logic anyPend, // Some line is pending.
    output logic [4:0] topIdx // Highest pending priority.
);
    // Lowest index first so that a higher index overrides it.
    always_comb begin
        anyPend = 1'b0;
        topIdx = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (pend[i]) begin
                anyPend = 1'b1;
                topIdx = 5'(i);
            end
        end
    end
endmodule // pmiv_prio
`default_nettype wire

// File: core/pmiv_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmiv_defs.svh"
module pmiv_core
    import pmiv_pkg::*;
(
    input wire logic sys_clk, // 40 MHz clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic powerUpFlag, // Power-up reset cause.
    input wire logic resetPinFlag, // Reset pin cause.
    input wire logic watchdogExpire, // Watchdog reset-mode expiry.
    input wire logic keyViolFlag, // Flash key violation.
    input wire logic [15:0] resetVecWord, // Word read at FFFE.
    input wire logic fetchValid, // CPU fetch strobe.
    input wire logic [15:0] fetchAddr, // CPU fetch address.
    input wire logic nmiPinFlag, // Non-maskable pin flag.
    input wire logic oscFaultFlag, // Oscillator fault flag.
    input wire logic accViolFlag, // Flash access violation flag.
    input wire logic watchdogFlag, // Watchdog interval flag.
    input wire logic ccr0Flag, // Timer capture/compare 0.
    input wire logic ccr12Flag, // Timer compare 1-2 or overflow.
    input wire logic converterFlag, // Converter done.
    input wire logic serialFlag, // Serial unit or start condition.
    input wire logic [7:0] port2Flags, // Port 2 pin flags.
    input wire logic [7:0] port1Flags, // Port 1 pin flags.
    input wire logic irqAck, // CPU takes the offered vector.
    input wire logic irqReturn, // CPU returns from handler.
    output logic irqReq, // Interrupt offered to CPU.
    output logic [15:0] irqVector, // Vector word address offered.
    output logic sysResetReq, // System reset request, high in each cycle after a cycle with a reset cause.
    output logic cpuRun, // CPU enabled.
    output logic mainClkEn, // Main clock enable.
    output logic subClkEn, // Sub-main clock enable.
    output logic auxClkEn, // Auxiliary clock enable.
    output logic dcoBiasEn, // Oscillator bias generator enable.
    output logic xtalEn, // Crystal oscillator enable.
    output logic irq // Block interrupt, level.
);
    function automatic logic [15:0] vecAddr(input logic [4:0] prio);
        vecAddr = `PMIV_VEC_BASE + {10'h000, prio, 1'b0};
    endfunction

    function automatic logic badFetch(input logic [15:0] a);
        logic okRam;
        logic okInfo;
        logic okCode;
        okRam = (a >= `PMIV_RAM_LO) && (a <= `PMIV_RAM_HI);
        okInfo = (a >= `PMIV_INFO_LO) && (a <= `PMIV_INFO_HI);
        okCode = (a >= `PMIV_CODE_LO);
        badFetch = !(okRam || okInfo || okCode);
    endfunction

    function automatic logic [5:0] gateFor(input pmiv_mode_t m,
                                           input logic dcoRun);
        case (m)
            `PMIV_M_RUN: gateFor = `PMIV_G_RUN;
            `PMIV_M_S0: gateFor = `PMIV_G_S0;
            `PMIV_M_S1: gateFor = {`PMIV_G_S0 & 6'h3D} | {4'h0, dcoRun, 1'b0};
            `PMIV_M_S2: gateFor = `PMIV_G_S2;
            `PMIV_M_S3: gateFor = `PMIV_G_S3;
            `PMIV_M_S4: gateFor = `PMIV_G_S4;
            default: gateFor = `PMIV_G_RUN;
        endcase
    endfunction

    pmiv_state_t state_r, state_nxt;
    pmiv_mode_t lvl_r, lvl_nxt;
    logic retSleep_r, retSleep_nxt;
    logic [`PMIV_CTRL_W-1:0] ctrl_r;
    logic [`PMIV_EVT_W-1:0] evt_r, evt_nxt, mask_r;
    logic [5:0] gate_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r, irqReq_r, sysReset_r, irq_r;
    logic [15:0] vec_r;

    // Bus decode.
    wire logic setupPh = psel && !penable;
    wire logic accessPh = psel && penable && pready_r;
    wire logic wrEn = accessPh && pwrite;
    wire logic hitMode = (paddr == `PMIV_A_MODE);
    wire logic hitCtrl = (paddr == `PMIV_A_CTRL);
    wire logic hitStat = (paddr == `PMIV_A_STAT);
    wire logic hitVec = (paddr == `PMIV_A_VEC);
    wire logic hitEvt = (paddr == `PMIV_A_EVT);
    wire logic hitMask = (paddr == `PMIV_A_MASK);
    wire logic mapped = hitMode || hitCtrl || hitStat || hitVec || hitEvt
                        || hitMask;
    // Codes above the deepest sleep level are ignored, not stored.
    wire logic modeLegal = (pwdata[2:0] <= `PMIV_M_S4);
    wire logic modeWr = wrEn && hitMode && modeLegal;
    wire pmiv_mode_t modeReq = pwdata[2:0];

    // Source qualification.
    wire logic gie = ctrl_r[`PMIV_C_GIE];
    wire logic fetchBad = fetchValid && badFetch(fetchAddr);
    wire logic resetCause = powerUpFlag || resetPinFlag || watchdogExpire
                            || keyViolFlag || fetchBad;
    wire logic nmiPend = (nmiPinFlag && ctrl_r[`PMIV_C_NMIEN])
                         || (oscFaultFlag && ctrl_r[`PMIV_C_OFEN])
                         || (accViolFlag && ctrl_r[`PMIV_C_ACCEN]);
    wire logic wdtPend = watchdogFlag && ctrl_r[`PMIV_C_WATCHDOG_IRQ_ENABLE]
                         && ctrl_r[`PMIV_C_WDTIVL] && gie;

    logic [31:0] pendLines;
    always_comb begin
        pendLines = 32'h0000_0000;
        pendLines[`PMIV_P_NMI] = nmiPend;
        pendLines[`PMIV_P_WDT] = wdtPend;
        pendLines[`PMIV_P_CC0] = ccr0Flag && gie;
        pendLines[`PMIV_P_CC12] = ccr12Flag && gie;
        pendLines[`PMIV_P_CONV] = converterFlag && gie;
        pendLines[`PMIV_P_SER] = serialFlag && gie;
        pendLines[`PMIV_P_PORT2] = (|port2Flags) && gie;
        pendLines[`PMIV_P_PORT1] = (|port1Flags) && gie;
    end

    logic pendValid;
    logic [4:0] pendIdx;
    pmiv_prio u_prio (
        .pend(pendLines),
        .anyPend(pendValid),
        .topIdx(pendIdx)
    );

    // Mode sequencer. A reset cause wins over everything else.
    logic wakeEvt, blankEvt;
    always_comb begin
        state_nxt = state_r;
        lvl_nxt = lvl_r;
        retSleep_nxt = retSleep_r;
        wakeEvt = 1'b0;
        blankEvt = 1'b0;
        if (resetCause) begin
            state_nxt = PMIV_BOOT;
            lvl_nxt = `PMIV_M_RUN;
            retSleep_nxt = 1'b0;
        end else begin
            unique case (state_r)
                PMIV_BOOT: begin
                    if (resetVecWord == `PMIV_BLANK_WORD) begin
                        state_nxt = PMIV_SLEEP;
                        lvl_nxt = `PMIV_M_S4;
                        blankEvt = 1'b1;
                    end else begin
                        state_nxt = PMIV_RUN;
                    end
                end
                PMIV_RUN: begin
                    if (irqReq_r && irqAck) begin
                        state_nxt = PMIV_SVC;
                        retSleep_nxt = 1'b0;
                    end else if (modeWr && modeReq != `PMIV_M_RUN) begin
                        state_nxt = PMIV_SLEEP;
                        lvl_nxt = modeReq;
                    end
                end
                PMIV_SLEEP: begin
                    if (pendValid) begin
                        state_nxt = PMIV_SVC;
                        retSleep_nxt = 1'b1;
                        wakeEvt = 1'b1;
                    end else if (modeWr && modeReq == `PMIV_M_RUN) begin
                        state_nxt = PMIV_RUN;
                        lvl_nxt = `PMIV_M_RUN;
                    end else if (modeWr) begin
                        lvl_nxt = modeReq;
                    end
                end
                PMIV_SVC: begin
                    // A handler may edit the level it will return to.
                    if (modeWr) begin
                        lvl_nxt = modeReq;
                        retSleep_nxt = (modeReq != `PMIV_M_RUN);
                    end
                    if (irqReturn) begin
                        state_nxt = retSleep_nxt ? PMIV_SLEEP : PMIV_RUN;
                    end
                end
            endcase
        end
    end

    wire pmiv_mode_t effMode = (state_r == PMIV_SLEEP) ? lvl_r
                               : `PMIV_M_RUN;
    wire logic [5:0] gateNow = gateFor(effMode, ctrl_r[`PMIV_C_DCORUN]);

    // Events: set wins over a write-one clear in the same cycle.
    wire logic [`PMIV_EVT_W-1:0] evtClr = (wrEn && hitEvt)
                                          ? pwdata[`PMIV_EVT_W-1:0]
                                          : {`PMIV_EVT_W{1'b0}};
    logic [`PMIV_EVT_W-1:0] evtSet;
    always_comb begin
        evtSet = {`PMIV_EVT_W{1'b0}};
        evtSet[`PMIV_E_WAKE] = wakeEvt;
        evtSet[`PMIV_E_FETCH] = fetchBad;
        evtSet[`PMIV_E_BLANK] = blankEvt;
        evtSet[`PMIV_E_RESET] = resetCause;
        evt_nxt = (evt_r & ~evtClr) | evtSet;
    end

    wire logic [31:0] statWord = {22'h000000, irqReq_r, state_r,
                                  retSleep_r, lvl_r, effMode == lvl_r};
    wire logic [31:0] rdMux = hitMode ? {29'h0, lvl_r}
                            : hitCtrl ? {25'h0, ctrl_r}
                            : hitStat ? statWord
                            : hitVec ? {16'h0000, vec_r}
                            : hitEvt ? {28'h0, evt_r}
                            : hitMask ? {28'h0, mask_r}
                            : 32'h0000_0000;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= PMIV_BOOT;
            lvl_r <= `PMIV_M_RUN;
            retSleep_r <= 1'b0;
            gate_r <= `PMIV_G_RUN;
        end else begin
            state_r <= state_nxt;
            lvl_r <= lvl_nxt;
            retSleep_r <= retSleep_nxt;
            gate_r <= gateNow;
        end
    end

    // Vector offer: reset vector overrides any maskable request.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irqReq_r <= 1'b0;
            vec_r <= `PMIV_VEC_RST;
            sysReset_r <= 1'b0;
        end else begin
            sysReset_r <= resetCause;
            irqReq_r <= pendValid && !resetCause
                        && (state_r != PMIV_BOOT);
            if (resetCause) begin
                vec_r <= vecAddr(`PMIV_P_RST);
            end else if (pendValid) begin
                vec_r <= vecAddr(pendIdx);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `PMIV_CTRL_RST;
            mask_r <= {`PMIV_EVT_W{1'b0}};
            evt_r <= {`PMIV_EVT_W{1'b0}};
            irq_r <= 1'b0;
        end else begin
            if (wrEn && hitCtrl) begin
                ctrl_r <= pwdata[`PMIV_CTRL_W-1:0];
            end
            if (wrEn && hitMask) begin
                mask_r <= pwdata[`PMIV_EVT_W-1:0];
            end
            evt_r <= evt_nxt;
            irq_r <= |(evt_r & mask_r);
        end
    end

    // Zero-wait slave: data is captured in setup, ready in access.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setupPh;
            pslverr_r <= setupPh && !mapped;
            if (setupPh && !pwrite) begin
                prdata_r <= rdMux;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irqReq = irqReq_r;
    assign irqVector = vec_r;
    assign sysResetReq = sysReset_r;
    assign cpuRun = gate_r[5];
    assign mainClkEn = gate_r[4];
    assign subClkEn = gate_r[3];
    assign auxClkEn = gate_r[2];
    assign dcoBiasEn = gate_r[1];
    assign xtalEn = gate_r[0];
    assign irq = irq_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    wire logic inSleep = (state_r == PMIV_SLEEP);

    sequence s_blankBoot;
        state_r == PMIV_BOOT && !resetCause
            && resetVecWord == `PMIV_BLANK_WORD;
    endsequence
    sequence s_deepSleep;
        inSleep && lvl_r == `PMIV_M_S4;
    endsequence

    property p_fullRun;
        state_r == PMIV_RUN |=> cpuRun && mainClkEn && subClkEn && auxClkEn;
    endproperty
    a_fullRun: assert property (p_fullRun)
        else $error("full run gating wrong");

    property p_sleep0;
        inSleep && lvl_r == `PMIV_M_S0 |=> !cpuRun && !mainClkEn
            && subClkEn && auxClkEn;
    endproperty
    a_sleep0: assert property (p_sleep0)
        else $error("sleep 0 gating wrong");

    property p_sleep1;
        inSleep && lvl_r == `PMIV_M_S1 |=> !cpuRun && subClkEn
            && dcoBiasEn == $past(ctrl_r[`PMIV_C_DCORUN]);
    endproperty
    a_sleep1: assert property (p_sleep1)
        else $error("sleep 1 bias wrong");

    property p_sleep2;
        inSleep && lvl_r == `PMIV_M_S2 |=> !mainClkEn && !subClkEn
            && dcoBiasEn && auxClkEn;
    endproperty
    a_sleep2: assert property (p_sleep2)
        else $error("sleep 2 gating wrong");

    property p_sleep3;
        inSleep && lvl_r == `PMIV_M_S3 |=> !subClkEn && !dcoBiasEn
            && auxClkEn && !cpuRun;
    endproperty
    a_sleep3: assert property (p_sleep3)
        else $error("sleep 3 gating wrong");

    property p_sleep4;
        s_deepSleep |=> !xtalEn && !auxClkEn && !dcoBiasEn && !cpuRun
            && !mainClkEn && !subClkEn;
    endproperty
    a_sleep4: assert property (p_sleep4)
        else $error("sleep 4 not fully stopped");

    property p_wake;
        inSleep && pendValid && !resetCause |=> state_r == PMIV_SVC
            ##1 cpuRun;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on pending interrupt");

    property p_restore;
        state_r == PMIV_SVC && irqReturn && retSleep_r && !modeWr
            && !resetCause |=> inSleep && lvl_r == $past(lvl_r);
    endproperty
    a_restore: assert property (p_restore)
        else $error("sleep level not restored");

    property p_blank;
        s_blankBoot |=> inSleep && lvl_r == `PMIV_M_S4 ##1 !xtalEn;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blank vector did not stop device");

    property p_fetch;
        fetchBad |=> sysResetReq && irqVector == `PMIV_VEC_RST
            && state_r == PMIV_BOOT;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("bad fetch gave no reset");

    // The encoder must pick a set line with nothing pending above it.
    property p_prio;
        pendValid && !resetCause |-> (pendLines >> pendIdx) == 32'h0000_0001
            ##1 irqVector == vecAddr($past(pendIdx));
    endproperty
    a_prio: assert property (p_prio)
        else $error("vector not highest priority");

    property p_nmiNoGie;
        nmiPend && !resetCause |=> irqVector == `PMIV_VEC_RST - 16'h0002;
    endproperty
    a_nmiNoGie: assert property (p_nmiNoGie)
        else $error("nmi group vector wrong");

    property p_wdtMode;
        !ctrl_r[`PMIV_C_WDTIVL] |-> !pendLines[`PMIV_P_WDT];
    endproperty
    a_wdtMode: assert property (p_wdtMode)
        else $error("watchdog irq in reset mode");

    property p_evtSticky;
        evtSet[`PMIV_E_WAKE] |=> evt_r[`PMIV_E_WAKE] [*2];
    endproperty
    a_evtSticky: assert property (p_evtSticky)
        else $error("wake event lost");
endmodule // pmiv_core
`default_nettype wire

// File: test/pmiv_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmiv_cpu_model (
    input wire logic sys_clk, // Clock.
    input wire logic nrst, // Reset, active low.
    input wire logic cpuRun, // CPU clock gate.
    input wire logic irqReq, // Offered interrupt.
    input wire logic [15:0] irqVector, // Offered vector word.
    input wire logic [7:0] hlen, // Handler length in cycles.
    output logic irqAck, // Take pulse.
    output logic irqReturn, // Return pulse.
    output logic [15:0] lastVec // Vector last taken.
);
    logic busy_r;
    logic [7:0] cnt_r;
    // A gated CPU cannot take an interrupt, so the ack waits for cpuRun.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            irqAck <= 1'b0;
            irqReturn <= 1'b0;
            lastVec <= 16'h0000;
        end else begin
            irqAck <= 1'b0;
            irqReturn <= 1'b0;
            if (!busy_r && cpuRun && irqReq && !irqAck && !irqReturn) begin
                irqAck <= 1'b1;
                busy_r <= 1'b1;
                lastVec <= irqVector;
                cnt_r <= hlen;
            end else if (busy_r && cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end else if (busy_r) begin
                irqReturn <= 1'b1;
                busy_r <= 1'b0;
            end
        end
    end
endmodule // pmiv_cpu_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmiv_defs.svh"
module tb_top import pmiv_pkg::*;;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [3:0] rstCause = 4'h0;
    logic [15:0] resetVecWord = 16'hFFFF;
    logic fetchValid = 1'b0;
    logic [15:0] fetchAddr = 16'hF000;
    logic [2:0] nmiFlags = 3'h0;
    logic [6:0] mFlags = 7'h00;
    logic [7:0] hlen = 8'h14;
    logic irqAck, irqReturn, irqReq, sysResetReq, irq;
    logic [15:0] irqVector, lastVec;
    logic cpuRun, mainClkEn, subClkEn, auxClkEn, dcoBiasEn, xtalEn;
    wire [5:0] gates = {cpuRun, mainClkEn, subClkEn, auxClkEn, dcoBiasEn,
        xtalEn};
    logic [5:0] gTab [6] = '{6'h3F, 6'h0F, 6'h0D, 6'h07, 6'h05, 6'h00};
    logic [15:0] vTab [7] = '{16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEA,
        16'hFFE8, 16'hFFE6, 16'hFFE4};
    logic [15:0] fTab [6] = '{16'h01FF, 16'h0000, 16'h0200, 16'h0FFF,
        16'h10FF, 16'hF000};
    logic [5:0] fBad = 6'b110100;
    int mismatches = 0;
    int checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    pmiv_core DUT (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .powerUpFlag(rstCause[3]),
        .resetPinFlag(rstCause[2]), .watchdogExpire(rstCause[1]),
        .keyViolFlag(rstCause[0]), .resetVecWord, .fetchValid, .fetchAddr,
        .nmiPinFlag(nmiFlags[2]), .oscFaultFlag(nmiFlags[1]),
        .accViolFlag(nmiFlags[0]), .watchdogFlag(mFlags[6]),
        .ccr0Flag(mFlags[5]), .ccr12Flag(mFlags[4]),
        .converterFlag(mFlags[3]), .serialFlag(mFlags[2]),
        .port2Flags({mFlags[1], 7'h00}), .port1Flags({7'h00, mFlags[0]}),
        .irqAck, .irqReturn, .irqReq, .irqVector, .sysResetReq, .cpuRun,
        .mainClkEn, .subClkEn, .auxClkEn, .dcoBiasEn, .xtalEn, .irq);

    pmiv_cpu_model cpu (.sys_clk, .nrst, .cpuRun, .irqReq, .irqVector,
        .hlen, .irqAck, .irqReturn, .lastVec);

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n < 16, 1'b1);
    endtask

    task waitEv(input logic ret);
        int n;
        n = 0;
        while ((ret ? irqReturn : irqAck) !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        #1;
        chk(n < 100, 1'b1);
    endtask

    task close_out;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // The full sequence needs a few hundred cycles; this leaves wide room.
    initial begin
        #(25 * 20000);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        cyc(4);
        chk(gates, 6'h00);
        @(posedge sys_clk);
        nrst <= 1'b0;
        resetVecWord <= 16'h4400;
        @(posedge sys_clk);
        nrst <= 1'b1;
        cyc(4);
        chk(gates, 6'h3F);
        apb(0, `PMIV_A_CTRL, 0);
        chk(rd, 0);
        apb(0, 8'h18, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        for (int i = 1; i < 6; i++) begin
            apb(1, `PMIV_A_MODE, i);
            cyc(3);
            chk(gates, gTab[i]);
            apb(0, `PMIV_A_MODE, 0);
            chk(rd, i);
        end
        apb(1, `PMIV_A_CTRL, 32'h40);
        apb(1, `PMIV_A_MODE, 2);
        cyc(3);
        chk(gates, 6'h0F);
        apb(1, `PMIV_A_MODE, 6);
        apb(0, `PMIV_A_MODE, 0);
        chk(rd, 2);
        apb(0, `PMIV_A_STAT, 0);
        chk(rd, 32'h0000_0085);
        apb(1, `PMIV_A_MODE, 4);
        apb(1, `PMIV_A_CTRL, 1);
        @(posedge sys_clk);
        mFlags <= 7'h08;
        waitEv(0);
        chk(gates, 6'h3F);
        chk(lastVec, 16'hFFEA);
        @(posedge sys_clk);
        mFlags <= 7'h00;
        waitEv(1);
        cyc(4);
        chk(gates, 6'h05);
        apb(1, `PMIV_A_CTRL, 32'h31);
        @(posedge sys_clk);
        mFlags <= 7'h7F;
        waitEv(0);
        apb(1, `PMIV_A_MODE, 0);
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            mFlags <= 7'h7F >> i;
            cyc(3);
            chk(irqVector, vTab[i]);
        end
        apb(1, `PMIV_A_CTRL, 32'h11);
        @(posedge sys_clk);
        mFlags <= 7'h40;
        cyc(3);
        chk(irqReq, 1'b0);
        apb(1, `PMIV_A_CTRL, 32'h31);
        cyc(3);
        chk({irqReq, irqVector}, 17'h1FFF4);
        apb(1, `PMIV_A_CTRL, 32'h30);
        cyc(3);
        chk(irqReq, 1'b0);
        @(posedge sys_clk);
        mFlags <= 7'h00;
        hlen <= 8'h02;
        cyc(30);
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            nmiFlags <= 3'b100 >> k;
            cyc(3);
            chk(irqReq, 1'b0);
            apb(1, `PMIV_A_CTRL, 2 << k);
            cyc(2);
            chk({irqReq, irqVector}, 17'h1FFFC);
            @(posedge sys_clk);
            nmiFlags <= 3'h0;
            cyc(20);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            rstCause <= 4'b1000 >> k;
            @(posedge sys_clk);
            rstCause <= 4'h0;
            #1;
            chk({sysResetReq, irqVector}, 17'h1FFFE);
            cyc(5);
        end
        for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk);
            fetchValid <= 1'b1;
            fetchAddr <= fTab[k];
            @(posedge sys_clk);
            fetchValid <= 1'b0;
            #1;
            chk(sysResetReq, fBad[5 - k]);
            cyc(5);
        end
        apb(0, `PMIV_A_VEC, 0);
        chk(rd, 32'h0000_FFFE);
        apb(0, `PMIV_A_EVT, 0);
        chk(rd[3], 1'b1);
        apb(1, `PMIV_A_MASK, 8);
        cyc(2);
        chk(irq, 1'b1);
        apb(1, `PMIV_A_MASK, 0);
        cyc(2);
        chk(irq, 1'b0);
        apb(1, `PMIV_A_MASK, 8);
        apb(1, `PMIV_A_EVT, 8);
        cyc(2);
        chk(irq, 1'b0);
        apb(0, `PMIV_A_EVT, 0);
        chk(rd[3], 1'b0);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
